// ---- design/sts_slave_tx.sv ----
// Purpose: two-wire slave transmitter with status codes and software handshake
// Assumes: scl/sda sampled from pins, register port on the same clock
// Notes: open-drain pins, oe_n low means the pin is pulled low
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "sts_params.svh"
module sts_slave_tx
  import sts_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_o_out,
  output logic scl_oe_n_out,
  output logic sda_o_out,
  output logic sda_oe_n_out,
  input wire logic arb_lost_in,
  input wire logic own_bus_in,
  output logic start_issue_out,
  output logic wake_out
);
  // synchronised pins and their previous values
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  // software visible state
  logic done_r; // job_done_flag
  logic ack_en_r; // ack_enable
  logic start_req_r; // start_request
  logic stop_req_r; // stop_request
  logic wcol_r; // write collision
  logic enable_r; // unit enable
  logic [1:0] presc_r; // prescaler bits, storage only here
  logic [7:0] status_r; // held status code
  logic [7:0] data_r; // shift_data_register as software sees it
  logic [6:0] own_addr_r; // own_address_field
  logic gc_en_r; // general_call_enable
  logic sleep_r; // deep sleep request
  // bus-side state
  sts_state_e state_r;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic last_r; // byte on the wire was sent as last
  logic nack_r; // master answered not-ack
  logic addr_full_r; // all eight address bits are in
  logic arb_r; // arbitration lost, awaiting address
  logic busy_r; // bus between start and stop
  logic start_pend_r; // start owed once bus free
  // decoded events
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic addr_hit;
  logic ev_addr;
  logic ev_tack;
  logic ev_err;
  logic sw_wr_ctrl;
  logic sw_go;

  // register selection, used by both write paths
  function automatic logic reg_sel(input logic [2:0] a, input logic [2:0] idx);
    reg_sel = (a == idx);
  endfunction

  sts_sync #(.WIDTH(`STS_SYNC_W)) u_sync
  (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // previous pin levels for edge finding
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  // data moving while clock high marks start or stop
  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
  // recognition needs ack enable; general call also needs its enable
  assign addr_hit = ack_en_r && ((shift_r[7:1] == own_addr_r) ||
                    (gc_en_r && shift_r[7:1] == `STS_GC_ADDR));
  // ack clock over: flag set with A8/B0
  assign ev_addr = (state_r == sts_aack) && scl_fall;
  // master ack clock over: flag set with B8/C0/C8
  assign ev_tack = (state_r == sts_tack) && scl_fall;
  // start or stop inside a frame is a bus error
  assign ev_err = (bus_start || bus_stop) &&
                  ((state_r == sts_addr && (bit_cnt_r != 3'h0 || addr_full_r)) ||
                   state_r == sts_aack ||
                   state_r == sts_txbit || state_r == sts_tack);
  assign sw_wr_ctrl = reg_wr_in && reg_sel(reg_addr_in, `STS_REG_CTRL);
  assign sw_go = sw_wr_ctrl && reg_wdata_in[`STS_CTL_DONE] && done_r;

  // flag and held status; a hardware set wins over a software clear
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      done_r <= 1'b0;
      status_r <= `STS_CODE_NONE;
    end
    else if (ev_err)
    begin
      done_r <= 1'b1;
      status_r <= `STS_CODE_BUS_ERR;
    end
    else if (ev_addr)
    begin
      done_r <= 1'b1;
      status_r <= arb_r ? `STS_CODE_ARB_RD : `STS_CODE_OWN_RD;
    end
    else if (ev_tack)
    begin
      done_r <= 1'b1;
      // not-ack wins; an ack after the last byte is C8
      if (nack_r)
        status_r <= `STS_CODE_DATA_NACK;
      else if (last_r)
        status_r <= `STS_CODE_LAST_ACK;
      else
        status_r <= `STS_CODE_DATA_ACK;
    end
    else if (sw_go)
    begin
      // code only changes once software lets go of the flag
      done_r <= 1'b0;
      status_r <= `STS_CODE_NONE;
    end
  end

  // control bits; recovery write clears stop and loads the rest as written
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ack_en_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      enable_r <= 1'b0;
    end
    else if (sw_wr_ctrl)
    begin
      ack_en_r <= reg_wdata_in[`STS_CTL_ACK];
      start_req_r <= reg_wdata_in[`STS_CTL_START];
      enable_r <= reg_wdata_in[`STS_CTL_EN];
      // slave has no stop to send: the bit self-clears on a go write
      stop_req_r <= reg_wdata_in[`STS_CTL_STOP] && !sw_go;
    end
  end

  // data, address, prescaler and sleep registers
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      data_r <= `STS_BYTE_ZERO;
      own_addr_r <= `STS_GC_ADDR;
      gc_en_r <= 1'b0;
      presc_r <= 2'h0;
      sleep_r <= 1'b0;
      wcol_r <= 1'b0;
    end
    else if (reg_wr_in)
    begin
      if (reg_sel(reg_addr_in, `STS_REG_DATA))
      begin
        // data only accepted while the flag holds the bus
        if (done_r)
        begin
          data_r <= reg_wdata_in;
          wcol_r <= 1'b0;
        end
        else
        begin
          wcol_r <= 1'b1;
        end
      end
      if (reg_sel(reg_addr_in, `STS_REG_ADDR))
      begin
        own_addr_r <= reg_wdata_in[7:1];
        gc_en_r <= reg_wdata_in[0];
      end
      if (reg_sel(reg_addr_in, `STS_REG_STATUS))
        presc_r <= reg_wdata_in[`STS_PS_HI:`STS_PS_LO];
      if (reg_sel(reg_addr_in, `STS_REG_SLEEP))
        sleep_r <= reg_wdata_in[0];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= `STS_BYTE_ZERO;
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `STS_REG_CTRL:
          reg_rdata_out <= {done_r, ack_en_r, start_req_r, stop_req_r,
                            wcol_r, enable_r, 2'h0};
        // flag clear always reads F8, stored code is already F8 then
        `STS_REG_STATUS:
          reg_rdata_out <= {status_r[`STS_ST_HI:`STS_ST_LO], 1'b0, presc_r};
        // after a deep-sleep wake this need not hold the last bus byte
        `STS_REG_DATA:
          reg_rdata_out <= data_r;
        `STS_REG_ADDR:
          reg_rdata_out <= {own_addr_r, gc_en_r};
        `STS_REG_SLEEP:
          reg_rdata_out <= {7'h00, sleep_r};
        default:
          reg_rdata_out <= `STS_BYTE_ZERO;
      endcase
    end
  end

  // bus busy tracking and lost-arbitration memory
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      busy_r <= 1'b0;
      arb_r <= 1'b0;
    end
    else
    begin
      if (bus_start)
        busy_r <= 1'b1;
      else if (bus_stop)
        busy_r <= 1'b0;
      // set wins over the clear at address completion
      if (arb_lost_in)
        arb_r <= 1'b1;
      else if (ev_addr || bus_stop)
        arb_r <= 1'b0;
    end
  end

  // owed start: free bus, or a repeated start while we still own it
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      start_pend_r <= 1'b0;
      start_issue_out <= 1'b0;
    end
    else
    begin
      start_issue_out <= 1'b0;
      if (sw_go && reg_wdata_in[`STS_CTL_START] &&
          (status_r == `STS_CODE_DATA_NACK || status_r == `STS_CODE_LAST_ACK))
        start_pend_r <= 1'b1;
      else if (start_pend_r && (!busy_r || own_bus_in))
      begin
        start_pend_r <= 1'b0;
        start_issue_out <= 1'b1;
      end
    end
  end

  // wake request: address matched while asleep, held until flag cleared
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      wake_out <= 1'b0;
    else if (ev_addr && sleep_r)
      wake_out <= 1'b1;
    else if (sw_go)
      wake_out <= 1'b0;
  end

  // open-drain levels: a pin is only ever pulled low, never driven high
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      scl_o_out <= 1'b0;
      sda_o_out <= 1'b0;
    end
    else
    begin
      scl_o_out <= 1'b0;
      sda_o_out <= 1'b0;
    end
  end

  // bus state machine; pins driven from flops
  always_ff @(posedge clock_in)
  begin
    if (reset_in || !enable_r)
    begin
      state_r <= sts_idle;
      shift_r <= `STS_BYTE_ZERO;
      bit_cnt_r <= 3'h0;
      last_r <= 1'b0;
      nack_r <= 1'b0;
      addr_full_r <= 1'b0;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end
    else if (ev_err)
    begin
      // let go of both lines at once so the bus can recover
      state_r <= sts_err;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end
    else
    begin
      case (state_r)
        sts_idle, sts_ignore:
        begin
          if (bus_start)
          begin
            state_r <= sts_addr;
            bit_cnt_r <= 3'h0;
            addr_full_r <= 1'b0;
          end
          else if (bus_stop)
            state_r <= sts_idle;
        end
        sts_addr:
        begin
          if (bus_start)
          begin
            bit_cnt_r <= 3'h0;
            addr_full_r <= 1'b0;
          end
          else if (bus_stop)
            state_r <= sts_idle;
          else if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            // the count wraps to zero, so remember that a byte is complete
            if (bit_cnt_r == `STS_LAST_BIT)
              addr_full_r <= 1'b1;
          end
          else if (scl_fall && addr_full_r && shift_r[0] && addr_hit)
          begin
            // eight bits in, read direction, recognised: pull ack
            state_r <= sts_aack;
            sda_oe_n_out <= 1'b0;
          end
          else if (scl_fall && addr_full_r)
            state_r <= sts_ignore;
        end
        sts_aack:
        begin
          if (scl_fall)
          begin
            // ack clock ended: release data, stretch the clock
            state_r <= sts_hold;
            sda_oe_n_out <= 1'b1;
            scl_oe_n_out <= 1'b0;
          end
        end
        sts_hold:
        begin
          if (sw_go)
          begin
            if (status_r == `STS_CODE_DATA_NACK || status_r == `STS_CODE_LAST_ACK)
            begin
              // leave transmitting; recognition now follows ack enable
              state_r <= sts_idle;
              scl_oe_n_out <= 1'b1;
            end
            else
            begin
              // first bit set up in the same cycle that the clock is released
              shift_r <= {data_r[6:0], 1'b1};
              sda_oe_n_out <= data_r[7];
              last_r <= !reg_wdata_in[`STS_CTL_ACK];
              bit_cnt_r <= 3'h0;
              state_r <= sts_txbit;
              scl_oe_n_out <= 1'b1;
            end
          end
        end
        sts_txbit:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == `STS_LAST_BIT)
            begin
              state_r <= sts_tack;
              sda_oe_n_out <= 1'b1;
            end
            else
            begin
              sda_oe_n_out <= shift_r[7];
              shift_r <= {shift_r[6:0], 1'b1};
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        sts_tack:
        begin
          if (scl_rise)
            nack_r <= sda_s;
          else if (scl_fall)
          begin
            // flag set now; hold the clock until software answers
            state_r <= sts_hold;
            scl_oe_n_out <= 1'b0;
          end
        end
        sts_err:
        begin
          // recovery needs stop with the go write; no stop on the wire
          if (sw_go && reg_wdata_in[`STS_CTL_STOP])
            state_r <= sts_idle;
        end
        default:
          state_r <= sts_idle;
      endcase
    end
  end
endmodule

// ---- design/sts_params.svh ----
// Purpose: constants for the slave-transmitter two-wire unit
// Assumes: 8-bit register port, 3-bit register index
// Notes: definitions only
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH
// register indices
`define STS_REG_CTRL 3'h0
`define STS_REG_STATUS 3'h1
`define STS_REG_DATA 3'h2
`define STS_REG_ADDR 3'h3
`define STS_REG_SLEEP 3'h4
// control register bit positions
`define STS_CTL_DONE 7
`define STS_CTL_ACK 6
`define STS_CTL_START 5
`define STS_CTL_STOP 4
`define STS_CTL_WCOL 3
`define STS_CTL_EN 2
// status register fields
`define STS_ST_HI 7
`define STS_ST_LO 3
`define STS_PS_HI 1
`define STS_PS_LO 0
// status codes, prescaler bits masked
`define STS_CODE_OWN_RD 8'hA8
`define STS_CODE_ARB_RD 8'hB0
`define STS_CODE_DATA_ACK 8'hB8
`define STS_CODE_DATA_NACK 8'hC0
`define STS_CODE_LAST_ACK 8'hC8
`define STS_CODE_NONE 8'hF8
`define STS_CODE_BUS_ERR 8'h00
// counts and reset values
`define STS_LAST_BIT 3'h7
`define STS_BYTE_ZERO 8'h00
`define STS_GC_ADDR 7'h00
`define STS_SYNC_W 2
`endif

// ---- design/sts_pkg.sv ----
// Purpose: types for the slave-transmitter two-wire unit
// Assumes: constants live in sts_params.svh
// Notes: state machine type only
package sts_pkg;
  // bus-side state of the slave transmitter
  typedef enum logic [2:0]
  {
    sts_idle,
    sts_addr,
    sts_aack,
    sts_hold,
    sts_txbit,
    sts_tack,
    sts_err,
    sts_ignore
  } sts_state_e;
endpackage

// ---- design/sts_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock_in
// Notes: only the second stage is visible outside
module sts_sync
  import sts_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read by the second stage only
  logic [WIDTH-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      // idle bus level is high, so reset to one
      always_ff @(posedge clock_in)
      begin
        if (reset_in)
        begin
          meta_r[g] <= 1'b1;
          sync_out[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= async_in[g];
          sync_out[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

// ---- dv/sts_tx_properties.sv ----
// Purpose: port assertions for the slave transmitter
// Assumes: pins and register port sampled on clock_in
// Notes: bound into sts_slave_tx below
`include "sts_params.svh"
module sts_tx_checker
  import sts_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_o_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_o_out,
  input wire logic sda_oe_n_out,
  input wire logic own_bus_in,
  input wire logic start_issue_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // recovery write: stop and done in one control write
  logic rcv_wr;
  assign rcv_wr = reg_wr_in && reg_addr_in == `STS_REG_CTRL && reg_wdata_in[7] && reg_wdata_in[4];
  a_resv_zero: assert property (reg_rd_in && reg_addr_in == `STS_REG_STATUS |=> !reg_rdata_out[2])
    else $error("status reserved bit set");
  a_scl_low_only: assert property (!scl_oe_n_out |-> !scl_o_out)
    else $error("scl driven high");
  a_sda_low_only: assert property (!sda_oe_n_out |-> !sda_o_out)
    else $error("sda driven high");
  a_stretch_low: assert property ($fell(scl_oe_n_out) |-> !scl_in)
    else $error("scl grabbed while high");
  // releasing sda with scl high would look like a stop
  a_sda_rel_low: assert property ($rose(sda_oe_n_out) |-> !scl_in)
    else $error("sda released while scl high");
  a_recover_release: assert property (rcv_wr |-> ##[1:4] (scl_oe_n_out && sda_oe_n_out))
    else $error("lines held after recovery");
  a_stop_cleared: assert property (rcv_wr ##1 (reg_rd_in && reg_addr_in == `STS_REG_CTRL) |=>
    !reg_rdata_out[4] && reg_rdata_out[6] == $past(reg_wdata_in[6], 2))
    else $error("stop bit kept or ack bit changed");
  a_start_free: assert property (start_issue_out |-> scl_in || $past(own_bus_in))
    else $error("start issued on busy bus");
  c_recover: cover property (rcv_wr);
  c_stretch: cover property ($fell(scl_oe_n_out));
  c_start: cover property (start_issue_out);
endmodule
bind sts_slave_tx sts_tx_checker u_chk (.clock_in, .reset_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .scl_in, .sda_in, .scl_o_out, .scl_oe_n_out,
  .sda_o_out, .sda_oe_n_out, .own_bus_in, .start_issue_out);

// ---- dv/sts_bus_master.sv ----
// Purpose: behavioural two-wire master receiver
// Assumes: open-drain lines, 1 means released
// Notes: 400 ns bit period, waits out clock stretching
module sts_bus_master
(
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  output logic scl_m_out,
  output logic sda_m_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall_err = 0; // stretches that never ended
  initial
  begin
    scl_m_out = 1'b1;
    sda_m_out = 1'b1;
  end
  // release scl, bounded wait for the slave to let go
  task automatic scl_up();
    int n;
    n = 0;
    scl_m_out = 1'b1;
    while (scl_line_in !== 1'b1 && n < 4000)
    begin
      #50;
      n++;
    end
    if (n == 4000)
      stall_err++;
  endtask
  // sda moves well after scl falls, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    #100;
    sda_m_out = b;
    #100;
    scl_up();
    #100;
    r = sda_line_in;
    #100;
    scl_m_out = 1'b0;
  endtask
  task automatic start_cond();
    sda_m_out = 1'b1;
    #100;
    scl_up();
    #100;
    sda_m_out = 1'b0;
    #200;
    scl_m_out = 1'b0;
  endtask
  task automatic stop_cond();
    #100;
    sda_m_out = 1'b0;
    #100;
    scl_up();
    #100;
    sda_m_out = 1'b1;
    #200;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // ack high drives the bit low and asks for more, ack low ends the read
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the slave transmitter
// Assumes: bus master model on the far side
// Notes: control values: C4 ack+done, 84 last byte, E4 with start
`include "sts_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] OWN_ADDR = 7'h2A; // arbitrary own address
  logic clock_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic arb_lost_in = 1'b0, own_bus_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic scl_o_out, scl_oe_n_out, sda_o_out, sda_oe_n_out, start_issue_out, wake_out;
  logic scl_m, sda_m, scl_w, sda_w;
  int n_fail = 0, check_count = 0;
  logic [7:0] start_cnt = 8'h00; // start pulses seen so far
  // the start pulse stands one cycle only, so count it as it passes
  always @(posedge clock_in)
    if (start_issue_out === 1'b1)
      start_cnt <= start_cnt + 8'h01;
  // pulled-up lines: low when any party pulls
  assign scl_w = scl_m & (scl_oe_n_out | scl_o_out);
  assign sda_w = sda_m & (sda_oe_n_out | sda_o_out);
  initial
    forever #25 clock_in = ~clock_in;
  sts_slave_tx DUT (.clock_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .scl_in(scl_w), .sda_in(sda_w), .scl_o_out, .scl_oe_n_out, .sda_o_out,
    .sda_oe_n_out, .arb_lost_in, .own_bus_in, .start_issue_out, .wake_out);
  sts_bus_master mst (.scl_line_in(scl_w), .sda_line_in(sda_w), .scl_m_out(scl_m),
    .sda_m_out(sda_m));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  // data appears in the cycle after the strobe and holds until the next read strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    d = reg_rdata_out;
  endtask
  // status with prescaler bits masked off
  task automatic get_status(output logic [7:0] s);
    rd(`STS_REG_STATUS, s);
    s = s & 8'hF8;
  endtask
  task automatic wait_done();
    logic [7:0] d;
    int n;
    d = 8'h00;
    n = 0;
    while (d[`STS_CTL_DONE] !== 1'b1 && n < 3000)
    begin
      rd(`STS_REG_CTRL, d);
      n++;
    end
    check("done flag", {7'h00, d[7]}, 8'h01);
  endtask
  task automatic t_ack_off();
    logic a;
    logic [7:0] s;
    wr(`STS_REG_CTRL, 8'h04);
    mst.start_cond();
    mst.write_byte({OWN_ADDR, 1'b1}, a);
    check("address refused", {7'h00, a}, 8'h00);
    mst.stop_cond();
    get_status(s);
    check("idle status", s, `STS_CODE_NONE);
    wr(`STS_REG_CTRL, 8'h44);
    $display("t_ack_off done");
  endtask
  task automatic t_err();
    logic a;
    logic [7:0] s;
    mst.start_cond();
    repeat (3) mst.bit_io(1'b1, a);
    mst.start_cond();
    wait_done();
    get_status(s);
    check("bus error status", s, `STS_CODE_BUS_ERR);
    @(posedge clock_in);
    reg_addr_in <= `STS_REG_CTRL;
    reg_wdata_in <= 8'hD4;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    check("control after recovery", reg_rdata_out & 8'h74, 8'h44);
    repeat (4) @(negedge clock_in);
    check("lines released", {6'h00, scl_oe_n_out, sda_oe_n_out}, 8'h03);
    mst.stop_cond();
    $display("t_err done");
  endtask
  // addressed read; last_ack picks the C8 or the C0 ending
  task automatic t_tx(input logic arb, input logic last_ack);
    logic a;
    logic [7:0] d, s, e;
    logic [7:0] n_start;
    e = arb ? `STS_CODE_ARB_RD : `STS_CODE_OWN_RD;
    n_start = start_cnt;
    if (!arb)
      wr(`STS_REG_SLEEP, 8'h01);
    @(posedge clock_in);
    arb_lost_in <= arb;
    mst.start_cond();
    mst.write_byte({OWN_ADDR, 1'b1}, a);
    @(posedge clock_in);
    arb_lost_in <= 1'b0;
    check("address ack", {7'h00, a}, 8'h01);
    wait_done();
    get_status(s);
    check("first status", s, e);
    check("wake request", {7'h00, wake_out}, {7'h00, !arb});
    repeat (20) @(posedge clock_in);
    get_status(s);
    check("held status", s, e);
    check("scl stretched", {7'h00, scl_oe_n_out}, 8'h00);
    wr(`STS_REG_DATA, 8'h5A);
    wr(`STS_REG_CTRL, 8'hC4);
    mst.read_byte(1'b1, d);
    check("first byte", d, 8'h5A);
    check("wake cleared", {7'h00, wake_out}, 8'h00);
    wait_done();
    get_status(s);
    check("acked byte status", s, `STS_CODE_DATA_ACK);
    wr(`STS_REG_DATA, 8'hA5);
    wr(`STS_REG_CTRL, 8'h84);
    mst.read_byte(last_ack, d);
    check("last byte", d, 8'hA5);
    wait_done();
    get_status(s);
    check("end status", s, last_ack ? `STS_CODE_LAST_ACK : `STS_CODE_DATA_NACK);
    wr(`STS_REG_CTRL, 8'hE4);
    get_status(s);
    check("cleared status", s, `STS_CODE_NONE);
    check("start held on busy bus", start_cnt, n_start);
    if (last_ack)
    begin
      mst.read_byte(1'b0, d);
      check("ignored read", d, 8'hFF);
    end
    else
    begin
      // still owning the bus: the start goes out with no stop before it
      @(posedge clock_in);
      own_bus_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      own_bus_in <= 1'b0;
      check("repeated start", start_cnt, n_start + 8'h01);
    end
    mst.stop_cond();
    repeat (8) @(posedge clock_in);
    check("start issued", start_cnt, n_start + 8'h01);
    $display("t_tx done");
  endtask
  task automatic give_verdict();
    n_fail += mst.stall_err;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the tests need well under a millisecond
  initial
  begin
    #3000000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    logic [7:0] s;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    get_status(s);
    check("reset status", s, `STS_CODE_NONE);
    wr(`STS_REG_ADDR, {OWN_ADDR, 1'b0});
    wr(`STS_REG_CTRL, 8'h44);
    t_ack_off();
    t_err();
    t_tx(1'b1, 1'b1);
    t_tx(1'b0, 1'b0);
    give_verdict();
  end
endmodule
